// file: rtl/abr_readout.sv
// Purpose: serial readout of a 20-bit converter, busy-indicator 4-wire and chain modes
// Assumes: all pins are asynchronous to clk and sampled by two flip-flops
// Notes:   serial clock must be far slower than clk; its edges are found by sampling
`timescale 1ns/1ps
`default_nettype none

// result buffer between converter core and serial shifter
module abr_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             in_ready,
   output var  logic             out_valid,
   output var  logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_ONE  = (AW+1)'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;

   // handshakes on both sides
   assign push       = in_valid && in_ready;
   assign pop        = out_valid && out_ready;
   assign count_next = count_reg + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);
   assign out_valid  = count_reg != '0;
   assign out_data   = mem[rd_ptr_reg];

   // storage has no reset, only pointers, count and ready do
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and occupancy; ready registered so the top sees a flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         in_ready   <= 1'b0;
      end else begin
         wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
         rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
         count_reg  <= count_next;
         in_ready   <= count_next != CNT_FULL;
      end
   end
endmodule // abr_fifo

module abr_readout (
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   input  wire logic                         conversion_start,
   input  wire logic                         sdi,
   input  wire logic                         sck,
   input  wire logic                         chain_mode,
   input  wire logic                         result_valid,
   input  wire logic [abr_pkg::WORD_W-1:0]   result_data,
   output var  logic                         result_ready,
   output var  logic                         sdo_reg,
   output var  logic                         sdo_oe_reg,
   output var  logic                         acquire_reg,
   output var  logic [abr_pkg::CFG_W-1:0]    cfg_reg
);
   localparam int MSB = abr_pkg::WORD_MSB;

   // pin synchronisers: stage 1 feeds stage 2 only
   logic [1:0] cnv_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic [1:0] sck_sync_reg;
   logic [1:0] mode_sync_reg;
   logic       cnv_d_reg;
   logic       sck_d_reg;
   logic       cnv_s;
   logic       sdi_s;
   logic       sck_s;
   logic       chain_s;
   logic       cnv_rise;
   logic       sck_rise;
   logic       sck_fall;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnv_sync_reg  <= '0;
         sdi_sync_reg  <= '0;
         sck_sync_reg  <= '0;
         mode_sync_reg <= '0;
         cnv_d_reg     <= 1'b0;
         sck_d_reg     <= 1'b0;
      end else begin
         cnv_sync_reg  <= {cnv_sync_reg[0], conversion_start};
         sdi_sync_reg  <= {sdi_sync_reg[0], sdi};
         sck_sync_reg  <= {sck_sync_reg[0], sck};
         mode_sync_reg <= {mode_sync_reg[0], chain_mode};
         cnv_d_reg     <= cnv_sync_reg[1];
         sck_d_reg     <= sck_sync_reg[1];
      end
   end

   // edge detection on the second stage only
   assign cnv_s    = cnv_sync_reg[1];
   assign sdi_s    = sdi_sync_reg[1];
   assign sck_s    = sck_sync_reg[1];
   assign chain_s  = mode_sync_reg[1];
   assign cnv_rise = cnv_s && !cnv_d_reg;
   assign sck_rise = sck_s && !sck_d_reg;
   assign sck_fall = !sck_s && sck_d_reg;

   // result buffer; conversion end waits for a word, and a full buffer stalls the core
   logic                       fifo_valid;
   logic [abr_pkg::WORD_W-1:0] fifo_data;
   logic                       load;

   abr_fifo #(
      .WIDTH (abr_pkg::WORD_W),
      .DEPTH (abr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (result_valid),
      .in_data   (result_data),
      .in_ready  (result_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (load)
   );

   // state, timer, shifter
   abr_pkg::abr_state_t        state_reg;
   abr_pkg::abr_state_t        state_next;
   logic [6:0]                 tmr_reg;
   logic [4:0]                 cnt_reg;
   logic [4:0]                 len_reg;
   logic                       stat_reg;
   logic                       cap_reg;
   logic [abr_pkg::WORD_W-1:0] shreg_reg;
   logic [abr_pkg::WORD_W-1:0] shreg_next;
   logic [abr_pkg::WORD_W-1:0] shift_base;
   logic [abr_pkg::WORD_W-1:0] ins_mask;
   logic [abr_pkg::WORD_W-1:0] chain_next;
   logic [abr_pkg::WR_W-1:0]   wr_reg;
   logic                       conv_over;
   logic                       busy_end;
   logic                       commit;
   logic                       sdo_next;
   logic                       oe_next;

   // decode of conversion end and readout end
   assign conv_over = (state_reg == abr_pkg::ST_CONV) && (tmr_reg >= abr_pkg::CONV_LAST);
   assign load      = conv_over && fifo_valid && !cnv_rise;
   assign busy_end  = (state_reg == abr_pkg::ST_READ) && !chain_s && sck_fall
                      && (cnt_reg == len_reg);
   // a write frame counts when start rises in chain mode with a write command
   assign commit    = chain_s && cnv_rise && (state_reg == abr_pkg::ST_IDLE)
                      && (wr_reg[abr_pkg::WR_W-1:abr_pkg::CFG_W] == abr_pkg::CMD_WRITE);

   // chain shift inserts the captured upstream bit just under the own word
   assign shift_base = {shreg_reg[MSB-1:0], 1'b0};
   assign ins_mask   = stat_reg ? abr_pkg::INS_MASK_STATUS : abr_pkg::INS_MASK_PLAIN;
   assign chain_next = (shift_base & ~ins_mask) | (cap_reg ? ins_mask : '0);

   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         abr_pkg::ST_IDLE: begin
            if (cnv_rise) begin
               state_next = abr_pkg::ST_CONV;
            end
         end
         abr_pkg::ST_CONV: begin
            if (load) begin
               state_next = abr_pkg::ST_READ;
            end
         end
         abr_pkg::ST_READ: begin
            if (cnv_rise) begin
               state_next = abr_pkg::ST_CONV;
            end else if (busy_end || (chain_s && !cnv_s)) begin
               state_next = abr_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = abr_pkg::ST_IDLE;
         end
      endcase
   end

   // output pin and shifter; readout bits move only on falling edges so they
   // stand across the following rising edge
   always_comb begin
      sdo_next   = sdo_reg;
      oe_next    = sdo_oe_reg;
      shreg_next = shreg_reg;
      if (cnv_rise && !chain_s) begin
         oe_next = 1'b0;
      end else if (cnv_rise) begin
         sdo_next = 1'b0;
         oe_next  = 1'b1;
      end else if (load) begin
         shreg_next = fifo_data;
         oe_next    = 1'b1;
         sdo_next   = chain_s ? fifo_data[MSB] : 1'b0;
      end else if (state_reg == abr_pkg::ST_READ && sck_fall) begin
         if (chain_s) begin
            shreg_next = chain_next;
            sdo_next   = chain_next[MSB];
         end else if (busy_end) begin
            oe_next = 1'b0;
         end else begin
            shreg_next = shift_base;
            sdo_next   = shreg_reg[MSB];
         end
      end else if (chain_s && state_reg == abr_pkg::ST_IDLE && !cnv_s) begin
         // only the forwarded input leaves, never register contents
         sdo_next = wr_reg[abr_pkg::FWD_TAP];
         oe_next  = 1'b1;
      end else if (!chain_s && state_reg == abr_pkg::ST_IDLE && !cnv_s) begin
         oe_next = 1'b0;
      end
   end

   // state and counters; timer holds at its end so a long fifo stall cannot wrap it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= abr_pkg::ST_IDLE;
         tmr_reg   <= abr_pkg::TMR_ZERO;
         cnt_reg   <= abr_pkg::CNT_ZERO;
      end else begin
         state_reg <= state_next;
         tmr_reg   <= (state_next == abr_pkg::ST_CONV && state_reg == abr_pkg::ST_CONV)
                      ? (conv_over ? tmr_reg : tmr_reg + abr_pkg::TMR_ONE) : abr_pkg::TMR_ZERO;
         if (load) begin
            cnt_reg <= abr_pkg::CNT_ZERO;
         end else if (state_reg == abr_pkg::ST_READ && sck_fall) begin
            cnt_reg <= cnt_reg + abr_pkg::CNT_ONE;
         end
      end
   end

   // word length fixed at load so a mid-frame write cannot change it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         len_reg  <= abr_pkg::LEN_PLAIN;
         stat_reg <= 1'b0;
      end else if (load) begin
         stat_reg <= cfg_reg[abr_pkg::CFG_STATUS_BIT];
         len_reg  <= cfg_reg[abr_pkg::CFG_STATUS_BIT] ? abr_pkg::LEN_STATUS
                                                      : abr_pkg::LEN_PLAIN;
      end
   end

   // pin outputs and shifter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sdo_reg    <= 1'b0;
         sdo_oe_reg <= 1'b0;
         shreg_reg  <= '0;
      end else begin
         sdo_reg    <= sdo_next;
         sdo_oe_reg <= oe_next;
         shreg_reg  <= shreg_next;
      end
   end

   // acquisition runs from conversion end to the next start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acquire_reg <= 1'b1;
      end else if (cnv_rise) begin
         acquire_reg <= 1'b0;
      end else if (load) begin
         acquire_reg <= 1'b1;
      end
   end

   // rising-edge capture: upstream bit for readout, write window otherwise
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cap_reg <= 1'b0;
         wr_reg  <= '0;
      end else if (sck_rise && chain_s) begin
         cap_reg <= sdi_s;
         if (!cnv_s) begin
            wr_reg <= {wr_reg[abr_pkg::WR_W-2:0], sdi_s};
         end
      end
   end

   // configuration: cleared at reset, written only by a chain write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= abr_pkg::CFG_RESET;
      end else if (commit) begin
         cfg_reg <= wr_reg[abr_pkg::CFG_W-1:0];
      end
   end

   // checks
   early_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(cfg_reg[abr_pkg::CFG_EARLY_BIT]) |-> $past(commit))
      else $error("early readout enabled without a write");
   start_hiz_a: assert property (@(posedge clk) disable iff (!reset_n)
      (cnv_rise && !chain_s) |=> !sdo_oe_reg && state_reg == abr_pkg::ST_CONV)
      else $error("busy start did not float output");
   eoc_low_a: assert property (@(posedge clk) disable iff (!reset_n)
      (load && !chain_s) |=> sdo_oe_reg && !sdo_reg && acquire_reg)
      else $error("end of conversion not driven low");
   msb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == abr_pkg::ST_READ && !chain_s && sck_fall && !cnv_rise
       && cnt_reg < len_reg) |=> sdo_reg == $past(shreg_reg[MSB]))
      else $error("busy bit order wrong");
   status_len_a: assert property (@(posedge clk) disable iff (!reset_n)
      load |=> len_reg == ($past(cfg_reg[abr_pkg::CFG_STATUS_BIT])
                           ? abr_pkg::LEN_STATUS : abr_pkg::LEN_PLAIN))
      else $error("word length wrong");
   hiz_end_a: assert property (@(posedge clk) disable iff (!reset_n)
      (busy_end && !cnv_rise) |=> !sdo_oe_reg && state_reg == abr_pkg::ST_IDLE)
      else $error("output not floated after last bit");
   bit_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == abr_pkg::ST_READ && $past(state_reg) == abr_pkg::ST_READ
       && !sck_fall && !cnv_rise && cnv_s) |=> $stable(sdo_reg))
      else $error("output changed off a falling edge");
   chain_low_a: assert property (@(posedge clk) disable iff (!reset_n)
      (chain_s && cnv_rise) |=> sdo_oe_reg && !sdo_reg)
      else $error("chain output not low at start");
   chain_msb_a: assert property (@(posedge clk) disable iff (!reset_n)
      (load && chain_s) |=> sdo_reg == $past(fifo_data[MSB]))
      else $error("chain msb not presented");
   chain_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg == abr_pkg::ST_READ && chain_s && sck_fall && !cnv_rise)
      |=> (stat_reg ? shreg_reg[0] : shreg_reg[abr_pkg::STAT_W]) == $past(cap_reg))
      else $error("upstream bit not passed on");
   write_take_a: assert property (@(posedge clk) disable iff (!reset_n)
      commit |=> cfg_reg == $past(wr_reg[abr_pkg::CFG_W-1:0]))
      else $error("chain write not accepted");
   no_regread_a: assert property (@(posedge clk) disable iff (!reset_n)
      (chain_s && state_reg == abr_pkg::ST_IDLE && !cnv_s && !cnv_rise && !sck_fall)
      |=> sdo_reg == $past(wr_reg[abr_pkg::FWD_TAP]))
      else $error("chain idle output not forwarded input");

   busy_read_c: cover property (@(posedge clk) disable iff (!reset_n) busy_end);
   chain_read_c: cover property (@(posedge clk) disable iff (!reset_n)
      load && chain_s ##[1:1000] sck_fall);
   cfg_write_c: cover property (@(posedge clk) disable iff (!reset_n) commit);
endmodule // abr_readout

`default_nettype wire

// file: rtl/abr_pkg.sv
// Purpose: shared constants and types of the converter readout block
// Assumes: core clock of 250 MHz; word is 20 result bits then 6 status bits
// Notes:   write command code and config bit positions are plain defaults
package abr_pkg;
   // word layout
   localparam int RES_W      = 20;
   localparam int STAT_W     = 6;
   localparam int WORD_W     = RES_W + STAT_W;
   localparam int WORD_MSB   = WORD_W - 1;
   localparam int FIFO_DEPTH = 16;

   // readout lengths in falling edges
   localparam logic [4:0] LEN_PLAIN  = 5'h14;
   localparam logic [4:0] LEN_STATUS = 5'h1a;
   localparam logic [4:0] CNT_ZERO   = 5'h00;
   localparam logic [4:0] CNT_ONE    = 5'h01;

   // chain insertion point: bit just below the word that is shifted out
   localparam logic [WORD_W-1:0] INS_MASK_PLAIN  = 26'h000_0040;
   localparam logic [WORD_W-1:0] INS_MASK_STATUS = 26'h000_0001;

   // conversion time, least time so rounded up
   localparam int CLK_PERIOD_NS = 4;
   localparam int CONV_TIME_NS  = 300;
   localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] CONV_LAST = 7'(CONV_CYCLES - 1);
   localparam logic [6:0] TMR_ZERO  = 7'h00;
   localparam logic [6:0] TMR_ONE   = 7'h01;

   // register write frame: command byte then data byte
   localparam int WR_W     = 16;
   localparam int CFG_W    = 8;
   localparam int FWD_TAP  = 7;
   localparam logic [7:0] CMD_WRITE = 8'h14;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam int CFG_EARLY_BIT  = 1;
   localparam int CFG_STATUS_BIT = 4;

   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_READ} abr_state_t;
endpackage

// file: bench/abr_host_model.sv
// Purpose: host side of the serial pins: conversion start, sdi and a 32 ns serial clock
// Assumes: clk is the 4 ns core clock; pins change just after its rising edge
// Notes:   sck stands low outside frames; tasks are called by the testbench
`timescale 1ns/1ps
`default_nettype none

module abr_host_model (
   input  wire logic clk,
   input  wire logic sdo_wire,
   output var  logic conversion_start,
   output var  logic sdi,
   output var  logic sck
);
   // all pins low from time zero, so no edge is seen at reset release
   initial begin
      conversion_start = 1'b0;
      sdi = 1'b0;
      sck = 1'b0;
   end

   // low gap then rise; sck held low while the conversion runs
   task automatic start_conv(input logic sdi_lvl);
      @(posedge clk);
      conversion_start <= 1'b0;
      sdi <= sdi_lvl;
      sck <= 1'b0;
      repeat (4) @(posedge clk);
      conversion_start <= 1'b1;
      @(posedge clk);
   endtask

   task automatic drop_start();
      @(posedge clk);
      conversion_start <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic set_sdi(input logic v);
      @(posedge clk);
      sdi <= v;
   endtask

   // one serial clock: high 4 clk, low 4 clk; sdo sampled twice while high
   task automatic shift_bit(input logic din, output logic q_rise, output logic q_late);
      @(posedge clk);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      q_rise = sdo_wire;
      @(posedge clk);
      @(negedge clk);
      q_late = sdo_wire;
      @(posedge clk);
      sck <= 1'b0;
      sdi <= din;
      repeat (3) @(posedge clk);
   endtask

   // command byte then data byte, msb first, 16 clocks for a single device
   task automatic write_word(input logic [15:0] w);
      logic a;
      logic b;
      @(posedge clk);
      sdi <= w[15];
      for (int i = 15; i >= 0; i--) begin
         shift_bit((i > 0) ? w[i-1] : 1'b0, a, b);
      end
   endtask
endmodule // abr_host_model

`default_nettype wire

// file: bench/test_abr_readout.sv
// Purpose: self-checking bench of the readout block in busy and chain modes
// Assumes: sdo line has a pull-up; host model drives all serial pins
// Notes:   the fifo is filled first, then each conversion consumes one word
`timescale 1ns/1ps
`default_nettype none

module test_abr_readout;
   logic                        clk;
   logic                        reset_n;
   logic                        chain_mode;
   logic                        result_valid;
   logic [abr_pkg::WORD_W-1:0]  result_data;
   logic                        result_ready;
   logic                        sdo_reg;
   logic                        sdo_oe_reg;
   logic                        acquire_reg;
   logic [abr_pkg::CFG_W-1:0]   cfg_reg;
   logic                        conversion_start;
   logic                        sdi;
   logic                        sck;
   wire                         sdo_wire;
   int                          failures;
   int                          checks;
   int                          cycles;

   // released line floats up through the pull-up
   assign sdo_wire = sdo_oe_reg ? sdo_reg : 1'b1;

   abr_readout u_dut (
      .clk(clk), .reset_n(reset_n), .conversion_start(conversion_start), .sdi(sdi),
      .sck(sck), .chain_mode(chain_mode), .result_valid(result_valid),
      .result_data(result_data), .result_ready(result_ready), .sdo_reg(sdo_reg),
      .sdo_oe_reg(sdo_oe_reg), .acquire_reg(acquire_reg), .cfg_reg(cfg_reg)
   );

   abr_host_model u_host (
      .clk(clk), .sdo_wire(sdo_wire), .conversion_start(conversion_start),
      .sdi(sdi), .sck(sck)
   );

   initial clk = 1'b0;
   always #2 clk = ~clk;

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         tally_and_finish();
      end
   end

   function automatic logic [25:0] word_of(input int i);
      return 26'(32'h02b4_c3d1 + i * 32'h0013_5791);
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wait_oe(input int limit);
      int n;
      n = 0;
      while (sdo_oe_reg !== 1'b1 && n < limit) begin
         @(negedge clk);
         n++;
      end
      chk("eoc_oe", 1, sdo_oe_reg);
   endtask

   // busy-mode conversion: float on start, end-of-conversion low after the conversion time
   task automatic busy_conv();
      u_host.start_conv(1'b1);
      repeat (5) @(negedge clk);
      chk("conv_float", 0, sdo_oe_reg);
      chk("conv_acq", 0, acquire_reg);
      u_host.set_sdi(1'b0);
      repeat (abr_pkg::CONV_CYCLES - 10) @(negedge clk);
      chk("conv_early", 0, sdo_oe_reg);
      wait_oe(20);
      chk("eoc_low", 0, sdo_reg);
      chk("eoc_acq", 1, acquire_reg);
   endtask

   // busy readout of n bits after the end-of-conversion sample
   task automatic busy_read(input logic [25:0] w, input int n);
      logic a;
      logic b;
      u_host.shift_bit(1'b0, a, b);
      chk("eoc_sample", 0, a);
      for (int j = 1; j <= n; j++) begin
         u_host.shift_bit(1'b0, a, b);
         chk("busy_bit", w[26-j], a);
         chk("bit_hold", a, b);
      end
   endtask

   // fill to refusal; one extra word offered while full must be dropped
   task automatic fill_fifo();
      int i;
      i = 0;
      @(posedge clk);
      result_valid <= 1'b1;
      result_data <= word_of(0);
      while (i < abr_pkg::FIFO_DEPTH) begin
         @(posedge clk);
         if (result_ready === 1'b1) begin
            i++;
            result_data <= word_of(i);
         end
      end
      repeat (3) @(posedge clk);
      result_valid <= 1'b0;
      @(negedge clk);
      chk("fifo_full", 0, result_ready);
   endtask

   task automatic busy_plain();
      busy_conv();
      busy_read(word_of(0), 20);
      repeat (2) @(negedge clk);
      chk("extra_fall_float", 0, sdo_oe_reg);
   endtask

   // chain: write status enable, then own word plus an upstream word
   task automatic chain_write_read();
      logic [25:0] up;
      logic [25:0] own;
      logic a;
      logic b;
      up = 26'h155_a3c6;
      own = word_of(1);
      u_host.drop_start();
      chain_mode <= 1'b1;
      u_host.set_sdi(1'b0);
      repeat (8) @(negedge clk);
      chk("chain_idle_oe", 1, sdo_oe_reg);
      chk("chain_idle_low", 0, sdo_reg);
      u_host.write_word(16'h1410);
      u_host.start_conv(1'b0);
      repeat (5) @(negedge clk);
      chk("cfg_written", 8'h10, cfg_reg);
      repeat (20) @(negedge clk);
      chk("conv_low", 0, sdo_wire);
      for (int n = 0; n < 100 && acquire_reg !== 1'b1; n++) @(negedge clk);
      chk("chain_msb", own[25], sdo_wire);
      u_host.set_sdi(up[25]);
      for (int k = 0; k < 52; k++) begin
         u_host.shift_bit((k < 25) ? up[24-k] : 1'b0, a, b);
         chk("chain_bit", (k < 26) ? own[25-k] : up[51-k], a);
         chk("chain_hold", a, b);
      end
   endtask

   // busy with status, then a start rise floats the line before any extra fall
   task automatic busy_status_restart();
      logic [25:0] w;
      w = word_of(2);
      u_host.drop_start();
      chain_mode <= 1'b0;
      repeat (6) @(posedge clk);
      busy_conv();
      // stop after the 26th fall so only the start rise can float the line
      busy_read(w, 25);
      repeat (2) @(negedge clk);
      chk("last_status", w[0], sdo_wire);
      chk("last_oe", 1, sdo_oe_reg);
      u_host.start_conv(1'b1);
      repeat (5) @(negedge clk);
      chk("restart_float", 0, sdo_oe_reg);
      u_host.set_sdi(1'b0);
      wait_oe(100);
   endtask

   // drain the rest; conversion end must stall once the fifo is empty
   task automatic drain_and_stall();
      for (int i = 4; i < abr_pkg::FIFO_DEPTH; i++) begin
         busy_conv();
      end
      chk("fifo_empty_ready", 1, result_ready);
      u_host.start_conv(1'b1);
      u_host.set_sdi(1'b0);
      repeat (150) @(negedge clk);
      chk("stall_no_eoc", 0, sdo_oe_reg);
      @(posedge clk);
      result_valid <= 1'b1;
      result_data <= word_of(20);
      @(posedge clk);
      result_valid <= 1'b0;
      wait_oe(20);
   endtask

   initial begin
      failures = 0;
      checks = 0;
      cycles = 0;
      reset_n = 1'b0;
      chain_mode = 1'b0;
      result_valid = 1'b0;
      result_data = '0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("rst_oe", 0, sdo_oe_reg);
      chk("rst_acq", 1, acquire_reg);
      chk("rst_cfg", 8'h00, cfg_reg);
      chk("rst_ready", 0, result_ready);
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      fill_fifo();
      busy_plain();
      chain_write_read();
      busy_status_restart();
      drain_and_stall();
      tally_and_finish();
   end
endmodule // test_abr_readout

`default_nettype wire
